// ===== dv/icec_ctrl_assertions.sv
/*
 * icec_ctrl_chk: port-level properties of icec_ctrl, bound below.
 * assumes: full-word writes (byteenable 4'hF) outside the master enable lane.
 */
`timescale 1ns/1ns
module icec_ctrl_chk #(
	parameter bit HAS_FAST = 1'b0 // fast link ports in use
) (
	input wire logic core_clk, // clock
	input wire logic rstn, // sync reset, active low
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	input wire logic [31:0] avs_readdata, // read data
	input wire logic avs_waitrequest, // stall
	input wire logic cascade_ack_out, // lower acknowledge
	input wire logic irq, // request output
	input wire logic [31:0] irq_vector // serviced index
);
	logic mirq_q, hwen_q, wr_ok;
	logic [31:0] en_q, en_d;
	assign wr_ok = avs_write && !avs_read;
	// ==========
	// shadow of the master enable word; hardware enable only ever sets
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			mirq_q <= 1'b0;
			hwen_q <= 1'b0;
		end else if (wr_ok && avs_address == icec_pkg::ICEC_MER_OFFS && avs_byteenable[0]) begin
			mirq_q <= avs_writedata[0];
			hwen_q <= hwen_q | avs_writedata[1];
		end
	end
	// shadow of the enable word, en_d lines up with the registered irq
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			en_q <= 32'h0000_0000;
			en_d <= 32'h0000_0000;
		end else begin
			en_d <= en_q;
			if (wr_ok && avs_address == icec_pkg::ICEC_IER_OFFS) en_q <= avs_writedata;
			else if (wr_ok && avs_address == icec_pkg::ICEC_SIE_OFFS) en_q <= en_q | avs_writedata;
			else if (wr_ok && avs_address == icec_pkg::ICEC_CIE_OFFS) en_q <= en_q & ~avs_writedata;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence mer_read_done;
		avs_read && !avs_waitrequest && avs_address == icec_pkg::ICEC_MER_OFFS;
	endsequence
	sequence read_answer;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	a_reset_quiet: assert property ($rose(rstn) |-> !irq && irq_vector == 32'hFFFF_FFFF)
		else $error("irq or vector not idle after reset");
	a_master_gates: assert property (!mirq_q |=> !irq)
		else $error("irq raised with master enable clear");
	a_mer_readback: assert property (mer_read_done |-> avs_readdata == {30'h0, hwen_q, mirq_q})
		else $error("master enable word reads wrong");
	a_read_stall: assert property ($rose(avs_read) |-> read_answer)
		else $error("read answer not after one wait cycle");
	a_vector_bounds: assert property (irq |-> irq_vector < 32'h0000_0020)
		else $error("vector beyond 32 sources");
	a_no_enable_quiet: assert property (en_q == 32'h0000_0000 |=> !irq)
		else $error("irq with no input enabled");
	a_vector_enabled: assert property (irq |-> en_d[irq_vector[4:0]])
		else $error("serviced position not enabled");
	a_no_fast_ack: assert property (!HAS_FAST |-> !cascade_ack_out)
		else $error("acknowledge without fast link");
endmodule
bind icec_ctrl icec_ctrl_chk #(.HAS_FAST(HAS_FAST)) u_chk (.core_clk, .rstn, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cascade_ack_out, .irq,
	.irq_vector);

// ===== dv/icec_lower_model.sv
/*
 * icec_lower_model: last instance of a cascade chain, standard interrupts only.
 * assumes: shares core_clk and rstn with the master; the bench drives want by NBA.
 */
`timescale 1ns/1ns
module icec_lower_model #(
	parameter int LAG = 5 // want to request takes LAG + 1 cycles, a slow lower instance
) (
	input wire logic core_clk, // shared clock
	input wire logic rstn, // sync reset, active low
	input wire logic want, // bench asks for a lower request
	input wire logic ack_in, // master acknowledge, unused in standard mode
	output logic irq_out, // request toward the master
	output logic [31:0] vec_out // vector lines, not driven in standard mode
);
	int lag_cnt;
	// ==========
	// both cascade parameters 0, same standard type as the master
	always_ff @(posedge core_clk) begin
		if (!rstn || !want) begin
			lag_cnt <= 0;
			irq_out <= 1'b0;
		end else if (lag_cnt < LAG) begin
			lag_cnt <= lag_cnt + 1;
		end else begin
			irq_out <= 1'b1; // level on the dedicated request line
		end
	end
	// ==========
	// undriven vector toggles so a stale value never passes for data
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			vec_out <= 32'h0000_0000;
		end else begin
			vec_out <= ~vec_out;
		end
	end
endmodule

// ===== dv/testbench.sv
/*
 * testbench: register-level tests of icec_ctrl as cascade master with a lower model.
 * assumes: reads answer after one wait cycle, writes never wait.
 */
`timescale 1ns/1ns
module testbench;
	logic core_clk, rstn, avs_read, avs_write, want, avs_waitrequest, low_irq, irq;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, interrupt_inputs, low_vec, irq_vector, rd;
	logic [3:0] avs_byteenable;
	logic cascade_ack, proc_ack, proc_clk, proc_rst;
	int bad_count, total_checks, cycles;
	// ==========
	// 250 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	icec_ctrl #(.NUM_INPUTS(28), .software_source_count(2), .CASCADE_ENABLE(1'b1), .CASCADE_MASTER(1'b1)) dut (
		.core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .interrupt_inputs, .cascade_irq_in(low_irq),
		.cascade_vector_in(low_vec), .cascade_ack_out(cascade_ack), .proc_ack, .proc_clk,
		.proc_rst, .irq, .irq_vector);
	icec_lower_model low (.core_clk, .rstn, .want, .ack_in(cascade_ack), .irq_out(low_irq), .vec_out(low_vec));
	// ==========
	// bus tasks: request held until waitrequest is seen low at an edge
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus_rd(a, rd);
		check(rd, exp);
	endtask
	// irq settles through the input synchroniser, so wait a bounded while
	task automatic wait_irq(input logic e);
		int n;
		n = 0;
		while (irq !== e && n < 16) begin
			@(posedge core_clk);
			n++;
		end
		check({31'h0, irq}, {31'h0, e});
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// hang guard, far above the fewer than two hundred cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			conclude();
		end
	end
	// ==========
	// main sequence
	initial begin
		rstn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		want = 1'b0;
		proc_ack = 1'b0;
		proc_clk = 1'b0;
		proc_rst = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		interrupt_inputs = 32'h0000_0000;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		rd_chk(icec_pkg::ICEC_MER_OFFS, 32'h0000_0000);
		rd_chk(icec_pkg::ICEC_IER_OFFS, 32'h0000_0000);
		rd_chk(icec_pkg::ICEC_IVR_OFFS, 32'hFFFF_FFFF);
		rd_chk(8'h40, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
		$display("test reset done");
		bus_wr(icec_pkg::ICEC_IER_OFFS, 32'h0000_000A);
		bus_wr(icec_pkg::ICEC_ISR_OFFS, 32'h0000_0008);
		repeat (3) @(posedge core_clk);
		check({31'h0, irq}, 32'h0000_0000);
		bus_wr(icec_pkg::ICEC_MER_OFFS, 32'h0000_0001);
		wait_irq(1'b1);
		check(irq_vector, 32'h0000_0003);
		bus_wr(icec_pkg::ICEC_ISR_OFFS, 32'h0000_0006);
		repeat (2) @(posedge core_clk);
		check(irq_vector, 32'h0000_0001);
		rd_chk(icec_pkg::ICEC_IPR_OFFS, 32'h0000_000A);
		bus_wr(icec_pkg::ICEC_MER_OFFS, 32'h0000_0000);
		wait_irq(1'b0);
		bus_wr(icec_pkg::ICEC_IAR_OFFS, 32'h0000_000E);
		rd_chk(icec_pkg::ICEC_ISR_OFFS, 32'h0000_0000);
		$display("test injection done");
		bus_wr(icec_pkg::ICEC_MER_OFFS, 32'h0000_0003);
		bus_wr(icec_pkg::ICEC_MER_OFFS, 32'h0000_0001);
		rd_chk(icec_pkg::ICEC_MER_OFFS, 32'h0000_0003);
		bus_wr(icec_pkg::ICEC_ISR_OFFS, 32'h0000_0008);
		rd_chk(icec_pkg::ICEC_ISR_OFFS, 32'h0000_0000);
		bus_wr(icec_pkg::ICEC_ISR_OFFS, 32'h1000_0000);
		rd_chk(icec_pkg::ICEC_ISR_OFFS, 32'h1000_0000);
		bus_wr(icec_pkg::ICEC_IAR_OFFS, 32'h1000_0000);
		interrupt_inputs <= 32'h0000_0018;
		wait_irq(1'b1);
		check(irq_vector, 32'h0000_0003);
		rd_chk(icec_pkg::ICEC_ISR_OFFS, 32'h0000_0008);
		interrupt_inputs <= 32'h0000_0000;
		bus_wr(icec_pkg::ICEC_IAR_OFFS, 32'h0000_0008);
		wait_irq(1'b0);
		$display("test hardware enable done");
		bus_wr(icec_pkg::ICEC_SIE_OFFS, 32'h8000_0000);
		want <= 1'b1;
		interrupt_inputs <= 32'h0000_0002;
		wait_irq(1'b1);
		// no processor clock attached: its reset must leave the request alone
		proc_rst <= 1'b1;
		proc_ack <= 1'b1;
		repeat (12) @(posedge core_clk);
		check({31'h0, irq}, 32'h0000_0001);
		check({31'h0, cascade_ack}, 32'h0000_0000);
		check(irq_vector, 32'h0000_0001);
		proc_rst <= 1'b0;
		proc_ack <= 1'b0;
		interrupt_inputs <= 32'h0000_0000;
		bus_wr(icec_pkg::ICEC_IAR_OFFS, 32'h0000_0002);
		repeat (3) @(posedge core_clk);
		check(irq_vector, 32'h0000_001F);
		bus_wr(icec_pkg::ICEC_CIE_OFFS, 32'h8000_0000);
		wait_irq(1'b0);
		want <= 1'b0;
		$display("test cascade done");
		conclude();
	end
endmodule

// ===== logic/icec_ctrl.sv
/*
 * icec_ctrl: interrupt controller core with enable sequence and cascade link, Avalon-MM slave.
 * assumes: interrupt_inputs and cascade request are asynchronous levels (synchronised here);
 * processor clock, when present, is sampled as an ordinary input in the core_clk domain.
 * limitation: the processor clock must run well below core_clk, as its edges are found by sampling.
 * limitation: the lower vector lines are taken without synchronisation; the lower instance holds
 * them steady while its request stands.
 */
// Functional notes
// - runs on core_clk; with processor clock, irq is re-timed to that clock's edges
// - rstn resets all; processor reset clears processor-side irq stage when attached
// - after reset every input and the irq output are disabled
// - an input is accepted only once its enable bit is 1 (the master's position 31 follows the cascade request without it); bit 0 highest priority
// - irq driven only while master irq enable bit is set
// - with hw_input_enable 0, writing 1 to a status bit marks an existing input pending
// - writing 1 to hw_input_enable enables hardware inputs, blocks injection, then locks
// - at most 32 sources per instance; more need cascade parameters
// - cascade request enters at the dedicated input or at input bit 31 only
// - on non-master cascaded instances other connected bits are ordinary inputs
// - cascade enable 0 with cascade master 1 is rejected at elaboration
// - master services inputs 0 to 30 before cascade position 31
// - only the enable-and-master instance talks to the processor; its bit 31 unused
// - standard mode adds request input; fast mode adds vector input and acknowledge
// - intermediate instances link upward and downward; their bit 31 unconnected (only the master takes cascade_irq_in; elsewhere bit 31 is an ordinary source)
// - master enable bit 0 gates requests, hw_input_enable is bit 1
// - software-only source bits stay writable after hw_input_enable is set
`timescale 1ns/1ns
module icec_ctrl #(
	parameter int NUM_INPUTS = 32, // hardware sources, software sources sit above them
	parameter int software_source_count = 0, // software-only sources
	parameter bit CASCADE_ENABLE = 1'b0, // cascade interrupt mode
	parameter bit CASCADE_MASTER = 1'b0, // primary instance of the chain
	parameter bit HAS_FAST = 1'b0, // fast interrupt link ports in use
	parameter bit HAS_PROC_CLK = 1'b0 // processor clock attached
) (
	input wire logic core_clk, // bus and core clock, 250 MHz
	input wire logic rstn, // synchronous reset, active low
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall until answer
	input wire logic [31:0] interrupt_inputs, // peripheral levels, active high
	input wire logic cascade_irq_in, // request from lower instance
	input wire logic [31:0] cascade_vector_in, // vector from lower instance (fast)
	output logic cascade_ack_out, // acknowledge toward lower instance (fast)
	input wire logic proc_ack, // processor acknowledge of current vector
	input wire logic proc_clk, // processor clock, sampled as a level
	input wire logic proc_rst, // processor-domain reset, active high
	output logic irq, // interrupt request, active high level
	output logic [31:0] irq_vector // index of serviced source, or lower vector
);
	localparam int TOTAL = NUM_INPUTS + software_source_count;
	localparam logic [31:0] HW_MASK = (NUM_INPUTS >= 32) ? 32'hFFFF_FFFF : ((32'h1 << NUM_INPUTS) - 32'h1);
	localparam logic [31:0] ALL_MASK = (TOTAL >= 32) ? 32'hFFFF_FFFF : ((32'h1 << TOTAL) - 32'h1);
	localparam logic [31:0] SW_MASK = ALL_MASK & ~HW_MASK;
	localparam bit CASC_ON = CASCADE_ENABLE && CASCADE_MASTER;
	// position 31 is the chain link on the master, so it must be enableable whatever the source count
	localparam logic [31:0] LINK_MASK = CASC_ON ? (32'h1 << icec_pkg::ICEC_CASCADE_BIT) : 32'h0000_0000;
	localparam logic [31:0] EN_MASK = ALL_MASK | LINK_MASK;

	// ==========================================================
	// build checks
	generate
		if (TOTAL > icec_pkg::ICEC_MAX_SOURCES) begin : g_too_many
			$error("more than 32 sources need cascade mode");
		end
		if (!CASCADE_ENABLE && CASCADE_MASTER) begin : g_bad_cascade
			$error("cascade master without cascade enable is illegal");
		end
		// on the chain master input 31 stays unconnected, so sources must fit below it
		if (CASC_ON && TOTAL > icec_pkg::ICEC_CASCADE_BIT) begin : g_link_overlap
			$error("chain master sources overlap the cascade position");
		end
	endgenerate

	// ==========================================================
	// input synchronisers
	logic [31:0] hw_sync;
	logic casc_sync;
	logic pclk_sync;
	logic prst_sync;

	icec_sync #(.WIDTH(32)) u_sync_in (
		.clk(core_clk),
		.rstn(rstn),
		.async_in(interrupt_inputs),
		.sync_out(hw_sync)
	);

	icec_sync #(.WIDTH(3)) u_sync_ctl (
		.clk(core_clk),
		.rstn(rstn),
		.async_in({cascade_irq_in, proc_clk, proc_rst}),
		.sync_out({casc_sync, pclk_sync, prst_sync})
	);

	// ==========================================================
	// state
	logic [31:0] status_reg;
	logic [31:0] interrupt_enable_reg;
	logic master_irq_enable;
	logic hw_input_enable;
	logic [31:0] hw_prev_reg;
	logic [31:0] vector_reg;
	logic pclk_prev_reg;
	logic irq_reg;

	// rising edge detection of the synchronised sources
	logic [31:0] src_now;
	logic [31:0] hw_rise;
	logic [31:0] active;
	logic wr_acc;
	logic rd_acc;

	// cascade link position: bit 31 on cascaded instances, replaced by the dedicated input on master
	always_comb begin
		src_now = hw_sync & HW_MASK;
		if (CASC_ON) begin
			src_now[icec_pkg::ICEC_CASCADE_BIT] = casc_sync;
		end
	end

	// on non-master instances all connected bits, including 31, are ordinary sources
	assign hw_rise = src_now & ~hw_prev_reg & {32{hw_input_enable}};
	assign active = status_reg & interrupt_enable_reg;
	assign wr_acc = avs_write && !avs_read;
	assign rd_acc = avs_read && !avs_write;

	// lowest index wins; position 31 only after 0..30 are clear
	function automatic logic [31:0] icec_prio(input logic [31:0] vec);
		logic [31:0] idx;
		idx = icec_pkg::ICEC_NO_VECTOR;
		for (int i = icec_pkg::ICEC_MAX_SOURCES - 1; i >= 0; i--) begin
			if (vec[i]) begin
				idx = 32'(i);
			end
		end
		return idx;
	endfunction

	// byte-enable merge of a write into a word
	function automatic logic [31:0] icec_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// bits selected by a write, masked by byte lanes
	logic [31:0] wr_bits;
	assign wr_bits = icec_merge(32'h0, avs_writedata, avs_byteenable);

	// ==========================================================
	// previous-sample register for edge detection
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hw_prev_reg <= icec_pkg::ICEC_WORD_RESET;
		end else begin
			hw_prev_reg <= src_now;
		end
	end

	// ==========================================================
	// status: hardware edges, software injection, acknowledge; set beats clear
	logic [31:0] status_next;
	always_comb begin
		status_next = status_reg;
		if (wr_acc && avs_address == icec_pkg::ICEC_IAR_OFFS) begin
			status_next = status_next & ~wr_bits;
		end
		if (wr_acc && avs_address == icec_pkg::ICEC_ISR_OFFS) begin
			if (!hw_input_enable) begin
				status_next = status_next | (wr_bits & ALL_MASK);
			end else begin
				status_next = status_next | (wr_bits & SW_MASK);
			end
		end
		// disabled inputs are not accepted, so only enabled edges latch
		status_next = status_next | (hw_rise & interrupt_enable_reg);
		// the lower instance holds its request until served below, so the link position
		// follows that level; an edge latch would lose a request raised before bit 31 is enabled
		if (CASC_ON && hw_input_enable) begin
			status_next[icec_pkg::ICEC_CASCADE_BIT] = casc_sync;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			status_reg <= icec_pkg::ICEC_WORD_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// ==========================================================
	// enable register with set and clear aliases
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			interrupt_enable_reg <= icec_pkg::ICEC_WORD_RESET;
		end else if (wr_acc) begin
			case (avs_address)
				icec_pkg::ICEC_IER_OFFS: begin
					interrupt_enable_reg <= icec_merge(interrupt_enable_reg, avs_writedata, avs_byteenable) & EN_MASK;
				end
				icec_pkg::ICEC_SIE_OFFS: begin
					interrupt_enable_reg <= interrupt_enable_reg | (wr_bits & EN_MASK);
				end
				icec_pkg::ICEC_CIE_OFFS: begin
					interrupt_enable_reg <= interrupt_enable_reg & ~wr_bits;
				end
				default: begin
					interrupt_enable_reg <= interrupt_enable_reg;
				end
			endcase
		end
	end

	// ==========================================================
	// master enable word decode; both bits sit in byte lane 0
	logic mer_wr;
	assign mer_wr = wr_acc && avs_address == icec_pkg::ICEC_MER_OFFS && avs_byteenable[0];

	// master irq enable: freely writable, a 0 masks every request
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			master_irq_enable <= 1'b0;
		end else if (mer_wr) begin
			master_irq_enable <= avs_writedata[icec_pkg::ICEC_MER_ME_BIT];
		end
	end

	// hardware input enable: write-once, a written 0 is ignored so the lock cannot be undone
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hw_input_enable <= 1'b0;
		end else if (mer_wr && avs_writedata[icec_pkg::ICEC_MER_HIE_BIT]) begin
			hw_input_enable <= 1'b1;
		end
	end

	// ==========================================================
	// request and vector; processor clock edges re-time the output when attached
	logic pclk_rise;
	logic irq_next;
	assign pclk_rise = pclk_sync && !pclk_prev_reg;
	assign irq_next = master_irq_enable && (active != 32'h0);

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pclk_prev_reg <= 1'b0;
		end else begin
			pclk_prev_reg <= pclk_sync;
		end
	end

	// processor-side stage: updates on processor clock edges when one is attached
	logic proc_hold;
	logic proc_step;
	logic [31:0] win_idx;
	assign proc_hold = HAS_PROC_CLK && prst_sync;
	assign proc_step = !HAS_PROC_CLK || pclk_rise;
	assign win_idx = icec_prio(active);

	// request level; the processor reset clears it alone, the bus side keeps its state
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			irq_reg <= 1'b0;
		end else if (proc_hold) begin
			irq_reg <= 1'b0;
		end else if (proc_step) begin
			irq_reg <= irq_next;
		end
	end

	// vector: on the fast link the lower instance's vector stands in for position 31
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			vector_reg <= icec_pkg::ICEC_NO_VECTOR;
		end else if (proc_hold) begin
			vector_reg <= icec_pkg::ICEC_NO_VECTOR;
		end else if (proc_step) begin
			if (CASC_ON && HAS_FAST && win_idx == 32'(icec_pkg::ICEC_CASCADE_BIT)) begin
				vector_reg <= cascade_vector_in;
			end else begin
				vector_reg <= win_idx;
			end
		end
	end

	assign irq = irq_reg;
	assign irq_vector = vector_reg;

	// acknowledge passes down the chain only when the cascade position is being served
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cascade_ack_out <= 1'b0;
		end else begin
			cascade_ack_out <= HAS_FAST && CASCADE_ENABLE && proc_ack
				&& vector_reg == cascade_vector_in && active[icec_pkg::ICEC_CASCADE_BIT];
		end
	end

	// ==========================================================
	// bus slave: one wait cycle on every read, writes taken at once
	// a read and a write together are ignored rather than guessed at
	logic rd_pend_reg;
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rd_pend_reg <= 1'b0;
		end else begin
			rd_pend_reg <= rd_acc && !rd_pend_reg;
		end
	end
	assign avs_waitrequest = rd_acc && !rd_pend_reg;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			avs_readdata <= icec_pkg::ICEC_UNMAPPED_READ;
		end else if (rd_acc && !rd_pend_reg) begin
			case (avs_address)
				icec_pkg::ICEC_ISR_OFFS: avs_readdata <= status_reg;
				icec_pkg::ICEC_IPR_OFFS: avs_readdata <= active;
				icec_pkg::ICEC_IER_OFFS: avs_readdata <= interrupt_enable_reg;
				icec_pkg::ICEC_IVR_OFFS: avs_readdata <= icec_prio(active);
				icec_pkg::ICEC_MER_OFFS: avs_readdata <= {30'h0, hw_input_enable, master_irq_enable};
				// write-only strobes read as zero, like unmapped words
				icec_pkg::ICEC_IAR_OFFS: avs_readdata <= icec_pkg::ICEC_UNMAPPED_READ;
				icec_pkg::ICEC_SIE_OFFS: avs_readdata <= icec_pkg::ICEC_UNMAPPED_READ;
				icec_pkg::ICEC_CIE_OFFS: avs_readdata <= icec_pkg::ICEC_UNMAPPED_READ;
				default: avs_readdata <= icec_pkg::ICEC_UNMAPPED_READ;
			endcase
		end
	end
endmodule

// ===== logic/icec_pkg.sv
/*
 * icec_pkg: register offsets, field positions, reset values and widths shared by the
 * interrupt controller and its Avalon-MM register slave.
 * assumes: 32-bit word-aligned Avalon-MM data bus, byte addresses.
 */
package icec_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ICEC_ISR_OFFS = 8'h00; // interrupt_status_reg
	localparam logic [7:0] ICEC_IPR_OFFS = 8'h04; // pending and enabled, read only
	localparam logic [7:0] ICEC_IER_OFFS = 8'h08; // interrupt_enable_reg
	localparam logic [7:0] ICEC_IAR_OFFS = 8'h0C; // acknowledge, write one to clear
	localparam logic [7:0] ICEC_SIE_OFFS = 8'h10; // set enable bits
	localparam logic [7:0] ICEC_CIE_OFFS = 8'h14; // clear enable bits
	localparam logic [7:0] ICEC_IVR_OFFS = 8'h18; // highest priority active index
	localparam logic [7:0] ICEC_MER_OFFS = 8'h1C; // master_enable_reg
	// ==========================================================
	// master enable fields
	localparam int ICEC_MER_ME_BIT = 0;
	localparam int ICEC_MER_HIE_BIT = 1;
	// ==========================================================
	// sizes and reset values
	localparam int ICEC_MAX_SOURCES = 32;
	localparam int ICEC_CASCADE_BIT = 31;
	localparam logic [31:0] ICEC_WORD_RESET = 32'h0000_0000;
	localparam logic [31:0] ICEC_NO_VECTOR = 32'hFFFF_FFFF;
	localparam logic [31:0] ICEC_UNMAPPED_READ = 32'h0000_0000;
	localparam int ICEC_SYNC_STAGES = 3;
endpackage

// ===== logic/icec_sync.sv
/*
 * icec_sync: three-stage synchroniser; output changes once stages two and three agree.
 * assumes: one destination clock, synchronous active-low reset.
 */
`timescale 1ns/1ns
module icec_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk, // destination clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic [WIDTH-1:0] async_in, // signal from another domain or a pin
	output logic [WIDTH-1:0] sync_out // filtered level
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	// ==========================================================
	// stage chain; s1 feeds only s2 to keep metastability contained
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// change accepted only when the two settled stages agree, per bit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					sync_out[i] <= s3_reg[i];
				end
			end
		end
	end
endmodule
